// ### hw/icra_bridge.sv
/*
  Host register set bridging to a slave core: single core register
  accesses through a data/command pair, and process RAM bursts through
  read and write FIFOs.
  Assumes the host port and the core request port share core_clk, and that
  the core answers each request with a one-cycle ack while req is high.
*/
`timescale 1ns/1ps
module icra_bridge #(
  parameter int FIFO_DEPTH = icra_pkg::ICRA_FIFO_DEPTH
) (
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  input  wire logic                     direct_mapped_mode,
  input  wire logic [icra_pkg::ICRA_AW-1:0] reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [31:0]              reg_wdata,
  output logic [31:0]                   reg_rdata,
  output logic                          reg_rvalid,
  output logic                          core_req,
  output logic                          core_we,
  output logic [15:0]                   core_addr,
  output logic [3:0]                    core_be,
  output logic [31:0]                   core_wdata,
  input  wire logic                     core_ack,
  input  wire logic [31:0]              core_rdata
);
  import icra_pkg::*;

  // ----------------------------------------------------------------
  // Host decode
  // ----------------------------------------------------------------
  logic acc_ok, w_data, w_cmd, w_rdal, w_rdcmd, w_wral, w_wrcmd;
  logic csr_start, rd_start, rd_abort, wr_start, wr_abort;

  assign acc_ok    = !direct_mapped_mode;
  assign w_data    = reg_wr && acc_ok && (reg_addr == ICRA_OFF_DATA);
  assign w_cmd     = reg_wr && acc_ok && (reg_addr == ICRA_OFF_CMD);
  assign w_rdal    = reg_wr && acc_ok && (reg_addr == ICRA_OFF_RD_AL);
  assign w_rdcmd   = reg_wr && acc_ok && (reg_addr == ICRA_OFF_RD_CMD);
  assign w_wral    = reg_wr && acc_ok && (reg_addr == ICRA_OFF_WR_AL);
  assign w_wrcmd   = reg_wr && acc_ok && (reg_addr == ICRA_OFF_WR_CMD);
  assign rd_start  = w_rdcmd && reg_wdata[ICRA_BUSY_BIT];
  assign rd_abort  = w_rdcmd && reg_wdata[ICRA_ABORT_BIT];
  assign wr_start  = w_wrcmd && reg_wdata[ICRA_BUSY_BIT];
  assign wr_abort  = w_wrcmd && reg_wdata[ICRA_ABORT_BIT];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  icra_port_st_t    state_q;
  logic             core_req_q, core_we_q;
  logic [15:0]      core_addr_q;
  logic [3:0]       core_be_q;
  logic [31:0]      core_wdata_q;
  logic [31:0]      csr_host_q, csr_core_q;
  logic             core_access_busy_q, csr_dir_q;
  logic [2:0]       core_access_size_q;
  logic [15:0]      core_reg_byte_address_q;
  logic             rd_busy_q, wr_busy_q;
  logic [15:0]      rd_addr_q, rd_len_q, wr_addr_q, wr_len_q;
  logic [31:0]      reg_rdata_q, rd_mux;
  logic             reg_rvalid_q;
  logic [2:0]       rd_step, wr_step;
  logic             csr_done, rd_done, wr_done;
  logic             rf_push, rf_pop, rf_in_ready, rf_out_valid;
  logic [31:0]      rf_out_data;
  logic             wf_push, wf_in_ready, wf_out_valid;
  logic [31:0]      wf_out_data;
  logic [ICRA_CNT_W-1:0] rf_count, wf_count, wf_free;

  assign csr_start = w_cmd && reg_wdata[ICRA_BUSY_BIT] && !core_access_busy_q;
  assign rd_step   = icra_step(rd_addr_q[1:0], rd_len_q);
  assign wr_step   = icra_step(wr_addr_q[1:0], wr_len_q);
  assign csr_done  = (state_q == ST_CSR) && core_ack;
  assign rd_done   = (state_q == ST_PRD) && core_ack;
  assign wr_done   = (state_q == ST_PWR) && core_ack;

  // ----------------------------------------------------------------
  // Process RAM FIFOs
  // ----------------------------------------------------------------
  // An ack that lands after an abort is dropped so no stale word is queued.
  assign rf_push = rd_done && rd_busy_q && !rd_abort;
  assign rf_pop  = reg_rd && acc_ok && rf_out_valid &&
                   icra_in_win(reg_addr, ICRA_RD_FIFO_LO, ICRA_RD_FIFO_HI);
  assign wf_push = reg_wr && acc_ok &&
                   icra_in_win(reg_addr, ICRA_WR_FIFO_LO, ICRA_WR_FIFO_HI);
  assign wf_free = ICRA_CNT_W'(FIFO_DEPTH) - wf_count;

  icra_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .CNT_W(ICRA_CNT_W)) u_rd_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .flush     (rd_abort),
    .in_valid  (rf_push),
    .in_ready  (rf_in_ready),
    .in_data   (core_rdata),
    .out_valid (rf_out_valid),
    .out_ready (rf_pop),
    .out_data  (rf_out_data),
    .count     (rf_count)
  );

  icra_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH), .CNT_W(ICRA_CNT_W)) u_wr_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .flush     (wr_abort),
    .in_valid  (wf_push),
    .in_ready  (wf_in_ready),
    .in_data   (reg_wdata),
    .out_valid (wf_out_valid),
    .out_ready (wr_done),
    .out_data  (wf_out_data),
    .count     (wf_count)
  );

  // ----------------------------------------------------------------
  // Core request port
  // ----------------------------------------------------------------
  // Single core register accesses take priority over bursts; burst words
  // keep their natural byte lanes, so only the enables mark valid bytes.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= ST_IDLE;
      core_req_q   <= 1'b0;
      core_we_q    <= 1'b0;
      core_addr_q  <= '0;
      core_be_q    <= '0;
      core_wdata_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (core_access_busy_q) begin
            state_q      <= ST_CSR;
            core_req_q   <= 1'b1;
            core_we_q    <= !csr_dir_q;
            core_addr_q  <= {core_reg_byte_address_q[15:2], 2'b00};
            core_be_q    <= icra_be(core_reg_byte_address_q[1:0], core_access_size_q);
            core_wdata_q <= 32'(csr_host_q << {core_reg_byte_address_q[1:0], 3'b000});
          end else if (rd_busy_q && (rd_len_q != '0) && rf_in_ready) begin
            state_q      <= ST_PRD;
            core_req_q   <= 1'b1;
            core_we_q    <= 1'b0;
            core_addr_q  <= {rd_addr_q[15:2], 2'b00};
            core_be_q    <= icra_be(rd_addr_q[1:0], rd_step);
          end else if (wr_busy_q && (wr_len_q != '0) && wf_out_valid) begin
            state_q      <= ST_PWR;
            core_req_q   <= 1'b1;
            core_we_q    <= 1'b1;
            core_addr_q  <= {wr_addr_q[15:2], 2'b00};
            core_be_q    <= icra_be(wr_addr_q[1:0], wr_step);
            core_wdata_q <= wf_out_data;
          end
        end
        default: begin
          if (core_ack) begin
            state_q    <= ST_IDLE;
            core_req_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core register data and command words
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      csr_host_q <= ICRA_WORD_RST;
      csr_dir_q  <= 1'b0;
      core_access_size_q <= '0;
      core_reg_byte_address_q <= '0;
    end else begin
      if (w_data) begin
        csr_host_q <= reg_wdata;
      end
      if (w_cmd) begin
        csr_dir_q  <= reg_wdata[ICRA_DIR_BIT];
        core_access_size_q <= reg_wdata[ICRA_SIZE_MSB:ICRA_SIZE_LSB];
        core_reg_byte_address_q <= reg_wdata[ICRA_ADDR_MSB:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_access_busy_q <= 1'b0;
      csr_core_q <= ICRA_WORD_RST;
    end else begin
      if (csr_start) begin
        core_access_busy_q <= 1'b1;
      end else if (csr_done) begin
        core_access_busy_q <= 1'b0;
      end
      if (csr_done && csr_dir_q) begin
        case (core_access_size_q)
          3'h1:    csr_core_q <= {24'h0, 8'(core_rdata >> {core_reg_byte_address_q[1:0], 3'b000})};
          3'h2:    csr_core_q <= {16'h0, 16'(core_rdata >> {core_reg_byte_address_q[1:0], 3'b000})};
          default: csr_core_q <= core_rdata;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Process RAM burst control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_busy_q <= 1'b0;
      rd_addr_q <= '0;
      rd_len_q  <= '0;
    end else begin
      if (rd_abort) begin
        rd_busy_q <= 1'b0;
      end else if (rd_start) begin
        rd_busy_q <= 1'b1;
      end else if (rd_busy_q && (rd_len_q == '0) && (state_q != ST_PRD)) begin
        rd_busy_q <= 1'b0;
      end
      if (w_rdal) begin
        rd_len_q  <= reg_wdata[31:ICRA_LEN_LSB];
        rd_addr_q <= reg_wdata[15:0];
      end else if (rf_push) begin
        rd_addr_q <= rd_addr_q + 16'(rd_step);
        rd_len_q  <= rd_len_q - 16'(rd_step);
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_busy_q <= 1'b0;
      wr_addr_q <= '0;
      wr_len_q  <= '0;
    end else begin
      if (wr_abort) begin
        wr_busy_q <= 1'b0;
      end else if (wr_start) begin
        wr_busy_q <= 1'b1;
      end else if (wr_busy_q && (wr_len_q == '0) && (state_q != ST_PWR)) begin
        wr_busy_q <= 1'b0;
      end
      if (w_wral) begin
        wr_len_q  <= reg_wdata[31:ICRA_LEN_LSB];
        wr_addr_q <= reg_wdata[15:0];
      end else if (wr_done && wr_busy_q) begin
        wr_addr_q <= wr_addr_q + 16'(wr_step);
        wr_len_q  <= wr_len_q - 16'(wr_step);
      end
    end
  end

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    if (acc_ok) begin
      if (icra_in_win(reg_addr, ICRA_RD_FIFO_LO, ICRA_RD_FIFO_HI)) begin
        rd_mux = rf_out_valid ? rf_out_data : '0;
      end else begin
        case (reg_addr)
          ICRA_OFF_DATA:   rd_mux = csr_dir_q ? csr_core_q : csr_host_q;
          ICRA_OFF_CMD:    rd_mux = {core_access_busy_q, csr_dir_q, 11'h0, core_access_size_q, core_reg_byte_address_q};
          ICRA_OFF_RD_AL:  rd_mux = {rd_len_q, rd_addr_q};
          ICRA_OFF_RD_CMD: rd_mux = {rd_busy_q, 18'h0, rf_count, 7'h0, rf_out_valid};
          ICRA_OFF_WR_AL:  rd_mux = {wr_len_q, wr_addr_q};
          ICRA_OFF_WR_CMD: rd_mux = {wr_busy_q, 18'h0, wf_free, 7'h0, wf_in_ready};
          default:         rd_mux = '0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q  <= '0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata  = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;
  assign core_req   = core_req_q;
  assign core_we    = core_we_q;
  assign core_addr  = core_addr_q;
  assign core_be    = core_be_q;
  assign core_wdata = core_wdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_csr_start_busy: assert property (@(posedge core_clk) disable iff (!resetn)
    csr_start |=> core_access_busy_q ##1 (state_q == ST_CSR && core_req_q))
    else $error("busy write did not launch a core access");
  a_core_access_busy_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    core_access_busy_q && !csr_done |=> core_access_busy_q)
    else $error("core access busy dropped before ack");
  a_csr_read_ready: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(core_access_busy_q) |-> $past(csr_done))
    else $error("busy cleared without core ack");
  a_zero_busy_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    w_cmd && !reg_wdata[ICRA_BUSY_BIT] && !core_access_busy_q |=> !core_access_busy_q)
    else $error("writing zero to busy started an access");
  a_direct_mode_hides: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_rd && direct_mapped_mode |=> reg_rvalid && (reg_rdata == 32'h0))
    else $error("register visible in direct mapped mode");
  a_req_until_ack: assert property (@(posedge core_clk) disable iff (!resetn)
    core_req_q && !core_ack |=> core_req_q && $stable(core_addr_q) && $stable(core_be_q))
    else $error("core request changed before ack");
  a_word_be_full: assert property (@(posedge core_clk) disable iff (!resetn)
    core_req_q && state_q == ST_CSR && core_access_size_q == 3'h4 |-> core_be_q == 4'hf)
    else $error("four-byte access lacks full byte enables");
  a_rd_abort_flush: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_abort |=> !rd_busy_q && rf_count == '0)
    else $error("read abort left busy or data");
  a_rd_empty_done: assert property (@(posedge core_clk) disable iff (!resetn)
    rd_busy_q && rd_len_q == '0 && state_q != ST_PRD && !rd_start |=> !rd_busy_q)
    else $error("read busy not cleared after burst");
  a_avail_count_pop: assert property (@(posedge core_clk) disable iff (!resetn)
    rf_pop && !rf_push && !rd_abort |=> rf_count == $past(rf_count) - 5'h1)
    else $error("available count did not drop on pop");

endmodule

// ### include/icra_pkg.sv
/*
  Shared constants, state type and lane helpers for the indirect core
  register and process RAM access bridge.
  Assumes a 32-bit host register port with byte offsets up to 3ffh.
*/
package icra_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int         ICRA_AW          = 10;
  localparam logic [9:0] ICRA_RD_FIFO_LO  = 10'h000;
  localparam logic [9:0] ICRA_RD_FIFO_HI  = 10'h01c;
  localparam logic [9:0] ICRA_WR_FIFO_LO  = 10'h020;
  localparam logic [9:0] ICRA_WR_FIFO_HI  = 10'h03c;
  localparam logic [9:0] ICRA_OFF_DATA    = 10'h300;
  localparam logic [9:0] ICRA_OFF_CMD     = 10'h304;
  localparam logic [9:0] ICRA_OFF_RD_AL   = 10'h308;
  localparam logic [9:0] ICRA_OFF_RD_CMD  = 10'h30c;
  localparam logic [9:0] ICRA_OFF_WR_AL   = 10'h310;
  localparam logic [9:0] ICRA_OFF_WR_CMD  = 10'h314;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ICRA_BUSY_BIT   = 31;
  localparam int          ICRA_DIR_BIT    = 30;
  localparam int          ICRA_ABORT_BIT  = 30;
  localparam int          ICRA_SIZE_LSB   = 16;
  localparam int          ICRA_SIZE_MSB   = 18;
  localparam int          ICRA_ADDR_MSB   = 15;
  localparam int          ICRA_LEN_LSB    = 16;
  localparam int          ICRA_FIFO_DEPTH = 16;
  localparam int          ICRA_CNT_W      = 5;
  localparam logic [31:0] ICRA_WORD_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CSR  = 2'b01,
    ST_PRD  = 2'b11,
    ST_PWR  = 2'b10
  } icra_port_st_t;

  // Bytes that fit in the current word: the rest of the word or the rest
  // of the transfer, whichever is smaller.
  function automatic logic [2:0] icra_step(input logic [1:0] lo, input logic [15:0] len);
    logic [2:0] room;
    room = 3'h4 - {1'b0, lo};
    icra_step = (len < {13'h0, room}) ? len[2:0] : room;
  endfunction

  function automatic logic [3:0] icra_be(input logic [1:0] lo, input logic [2:0] n);
    logic [3:0] m;
    case (n)
      3'h1:    m = 4'h1;
      3'h2:    m = 4'h3;
      3'h3:    m = 4'h7;
      default: m = 4'hf;
    endcase
    icra_be = 4'(m << lo);
  endfunction

  function automatic logic icra_in_win(input logic [9:0] a, input logic [9:0] lo,
                                       input logic [9:0] hi);
    icra_in_win = (a >= lo) && (a <= hi);
  endfunction

endpackage

// ### hw/icra_fifo.sv
/*
  Word FIFO with show-ahead output, valid/ready on both sides and a
  synchronous flush.
  Assumes one clock; flush wins over a push or pop in the same cycle.
*/
`timescale 1ns/1ps
module icra_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = icra_pkg::ICRA_FIFO_DEPTH,
  parameter int CNT_W = icra_pkg::ICRA_CNT_W
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CNT_W-1:0]      count
);
  import icra_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [CNT_W-1:0] cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != CNT_W'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= PW'(wp_q + 1'b1);
      end
      if (pop) begin
        rp_q <= PW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CNT_W'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CNT_W'(cnt_q - 1'b1);
      end
    end
  end

endmodule

// ### testbench/icra_core_model.sv
/*
  Behavioural slave core: a word memory that answers each request with a
  one-cycle ack after a programmable wait.
  Assumes one outstanding request and the bridge clock.
*/
`timescale 1ns/1ps
module icra_core_model (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        core_req,
  input  wire logic        core_we,
  input  wire logic [15:0] core_addr,
  input  wire logic [3:0]  core_be,
  input  wire logic [31:0] core_wdata,
  output logic             core_ack,
  output logic [31:0]      core_rdata
);
  logic [31:0] mem [0:16383];
  logic [3:0]  wait_q;

  // Read data is only valid with the ack; it toggles otherwise so that
  // a bridge sampling at the wrong edge is caught.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      core_ack   <= 1'b0;
      core_rdata <= 32'h5a5a_a5a5;
      wait_q     <= 4'h0;
    end else begin
      core_ack <= 1'b0;
      if (core_req && !core_ack && wait_q >= ack_delay) begin
        core_ack <= 1'b1;
        wait_q   <= 4'h0;
        if (core_we) begin
          for (int i = 0; i < 4; i++) begin
            if (core_be[i]) begin
              mem[core_addr[15:2]][8*i+:8] <= core_wdata[8*i+:8];
            end
          end
        end else begin
          core_rdata <= mem[core_addr[15:2]];
        end
      end else begin
        core_rdata <= ~core_rdata;
        if (core_req && !core_ack) begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// ### testbench/testbench.sv
/*
  Self-checking bench for the bridge: host register accesses, single core
  accesses and process RAM bursts against a behavioural core.
  Assumes the bridge answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module testbench;
  import icra_pkg::*;
  logic        core_clk, resetn, dmm, reg_wr, reg_rd, reg_rvalid;
  logic        core_req, core_we, core_ack;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, core_wdata, core_rdata, rd_q;
  logic [15:0] core_addr;
  logic [3:0]  core_be, dly;
  int          failures, num_checks;

  icra_bridge u_dut (.core_clk(core_clk), .resetn(resetn), .direct_mapped_mode(dmm),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .core_req(core_req),
    .core_we(core_we), .core_addr(core_addr), .core_be(core_be),
    .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata));
  icra_core_model u_core (.core_clk(core_clk), .resetn(resetn), .ack_delay(dly),
    .core_req(core_req), .core_we(core_we), .core_addr(core_addr), .core_be(core_be),
    .core_wdata(core_wdata), .core_ack(core_ack), .core_rdata(core_rdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    rd_q = reg_rdata;
    chk({31'h0, reg_rvalid}, 32'h1);
  endtask
  task automatic poll(input logic [9:0] a);
    repeat (40) begin
      rd(a);
      if (rd_q[31] === 1'b0) break;
    end
  endtask
  task automatic t_reset();
    rd(10'h300); chk(rd_q, 32'h0);
    rd(10'h304); chk(rd_q, 32'h0);
    rd(10'h30c); chk(rd_q, 32'h0);
    rd(10'h314); chk(rd_q, 32'h0000_1001);
  endtask
  task automatic t_single();
    logic [31:0] cmd [3] = '{32'hc002_0122, 32'hc004_0120, 32'hc001_0121};
    logic [31:0] exp [3] = '{32'h1234, 32'h1234_5678, 32'h56};
    dly = 4'h8;
    u_core.mem[14'h48] = 32'h0;
    wr(10'h300, 32'hab);
    wr(10'h304, 32'h8001_0123);
    rd(10'h304); chk({31'h0, rd_q[31]}, 32'h1);
    poll(10'h304); chk(rd_q, 32'h0001_0123);
    chk(u_core.mem[14'h48], 32'hab00_0000);
    rd(10'h300); chk(rd_q, 32'hab);
    u_core.mem[14'h48] = 32'h1234_5678;
    for (int i = 0; i < 3; i++) begin
      wr(10'h304, cmd[i]);
      poll(10'h304);
      rd(10'h300); chk(rd_q, exp[i]);
    end
  endtask
  task automatic t_zero_busy();
    logic seen = 1'b0;
    wr(10'h304, 32'h4001_0120);
    repeat (12) begin
      @(negedge core_clk);
      if (core_req !== 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
    rd(10'h300); chk(rd_q, 32'h56);
  endtask
  task automatic t_direct();
    dmm = 1'b1;
    wr(10'h304, 32'h8004_0000);
    rd(10'h304); chk(rd_q, 32'h0);
    dmm = 1'b0;
    rd(10'h304); chk(rd_q, 32'h4001_0120);
  endtask
  task automatic t_burst_read();
    dly = 4'h0;
    u_core.mem[14'h400] = 32'h4433_2211;
    u_core.mem[14'h401] = 32'h8877_6655;
    wr(10'h308, {16'h6, 16'h1001});
    wr(10'h30c, 32'h8000_0000);
    poll(10'h30c); chk(rd_q, 32'h0000_0201);
    rd(10'h01c); chk(rd_q & 32'hffff_ff00, 32'h4433_2200);
    rd(10'h30c); chk(rd_q, 32'h0000_0101);
    rd(10'h000); chk(rd_q & 32'h00ff_ffff, 32'h0077_6655);
    rd(10'h30c); chk(rd_q, 32'h0);
    dly = 4'hf;
    wr(10'h308, {16'h8, 16'h1000});
    wr(10'h30c, 32'h8000_0000);
    wr(10'h30c, 32'h4000_0000);
    rd(10'h30c); chk(rd_q, 32'h0);
    repeat (24) @(negedge core_clk);
    rd(10'h30c); chk(rd_q, 32'h0);
  endtask
  task automatic t_burst_write();
    dly = 4'h2;
    u_core.mem[14'h440] = 32'h0;
    u_core.mem[14'h441] = 32'h1111_1111;
    wr(10'h020, 32'hdead_beef);
    wr(10'h03c, 32'h0000_00aa);
    rd(10'h314); chk(rd_q, 32'h0000_0e01);
    wr(10'h310, {16'h5, 16'h1100});
    wr(10'h314, 32'h8000_0000);
    poll(10'h314); chk(rd_q, 32'h0000_1001);
    chk(u_core.mem[14'h440], 32'hdead_beef);
    chk(u_core.mem[14'h441], 32'h1111_11aa);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
  initial begin
    {resetn, dmm, reg_wr, reg_rd, reg_addr, reg_wdata, dly} = '0;
    repeat (10) @(negedge core_clk);
    resetn = 1'b1;
    t_reset();
    t_single();
    t_zero_busy();
    t_direct();
    t_burst_read();
    t_burst_write();
    end_of_test();
  end
endmodule
